/* File: bench/pcs_core_monitor.sv */
// Checker of counter, stack and indirect rules
`timescale 1ns/100ps
module pcs_core_monitor
  import pcs_pkg::*;
(
  input logic        sys_clk,
  input logic        resetn,
  input logic        clk_en,
  input pcs_op_type  flow_op,
  input logic [10:0] target_addr,
  input logic [12:0] intr_vector,
  input logic        pc_low_write,
  input logic        latch_write,
  input logic [7:0]  write_data,
  input logic [7:0]  status_reg,
  input logic [12:0] fetch_addr,
  input logic [7:0]  pc_high_latch,
  input logic [7:0]  indirect_pointer,
  input logic [8:0]  indirect_addr,
  input logic        indirect_write_en,
  input logic [7:0]  indirect_data_port
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_op(pcs_op_type o); clk_en && flow_op == o; endsequence
  AST_NEXT: assert property (s_op(PCS_OP_NEXT) ##0 !pc_low_write |=> fetch_addr == $past(fetch_addr) + 13'h1)
    else $error("no step");
  AST_JUMP: assert property (s_op(PCS_OP_JUMP) |=> fetch_addr == {$past(pc_high_latch[4:3]), $past(target_addr)})
    else $error("bad jump");
  AST_INTR: assert property (s_op(PCS_OP_INTR) |=> fetch_addr == $past(intr_vector))
    else $error("bad vector");
  AST_RET: assert property (s_op(PCS_OP_CALL) ##1 s_op(PCS_OP_RETURN) |=> fetch_addr == $past(fetch_addr, 2))
    else $error("bad return");
  AST_LATCH: assert property (clk_en && !latch_write && flow_op inside {PCS_OP_CALL, PCS_OP_RETURN}
    |=> $stable(pc_high_latch)) else $error("latch moved");
  AST_LOWW: assert property (clk_en && pc_low_write && flow_op inside {PCS_OP_NEXT, PCS_OP_HOLD}
    |=> fetch_addr == {$past(pc_high_latch[4:0]), $past(write_data)}) else $error("bad low write");
  AST_NULL: assert property (indirect_pointer == 8'h00 |-> indirect_data_port == 8'h00 && !indirect_write_en)
    else $error("port 0 leak");
  AST_EA: assert property (indirect_addr == {status_reg[7], indirect_pointer})
    else $error("bad address");
endmodule : pcs_core_monitor

/* File: bench/pcs_core_test.sv */
// Self-checking bench of the counter, stack and indirect block
`timescale 1ns/100ps
module pcs_core_test import pcs_pkg::*;;
  logic sys_clk = 1'h0, resetn = 1'h0, clk_en = 1'h1, port_read = 1'h1, port_write = 1'h1;
  logic pc_low_write = 1'h0, latch_write = 1'h0, pointer_write = 1'h0, indirect_read_en, indirect_write_en;
  pcs_op_type flow_op = PCS_OP_HOLD;
  logic [10:0] target_addr = 11'h0;
  logic [12:0] intr_vector = 13'h0abc, fetch_addr;
  logic [7:0] write_data = 8'h0, status_reg = 8'h80, file_read_data, pc_low_byte, pc_high_latch;
  logic [7:0] indirect_pointer, indirect_data_port;
  logic [8:0] indirect_addr;
  int miscompares = 0, checked = 0;
  pcs_core dut (.*);
  pcs_file_model model (.indirect_addr(indirect_addr), .file_read_data(file_read_data));
  always #50 sys_clk = ~sys_clk;
  task chk(input logic [12:0] seen, input logic [12:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task step(input pcs_op_type o, input logic [10:0] t = 11'h0);
    @(posedge sys_clk);
    flow_op <= o;
    target_addr <= t;
  endtask : step
  task run(input pcs_op_type o, input logic [10:0] t = 11'h0);
    step(o, t);
    step(PCS_OP_HOLD);
    #1;
  endtask : run
  // Select order: low byte, pointer, latch
  task wr(input logic [2:0] sel, input logic [7:0] v);
    @(posedge sys_clk);
    {pc_low_write, pointer_write, latch_write} <= sel;
    write_data <= v;
    @(posedge sys_clk);
    {pc_low_write, pointer_write, latch_write} <= 3'h0;
    #1;
  endtask : wr
  task t_page;
    wr(3'h1, 8'h08);
    run(PCS_OP_JUMP, 11'h7ff);
    chk(fetch_addr, 13'h0fff);
    run(PCS_OP_NEXT);
    chk(fetch_addr, 13'h1000);
    wr(3'h4, 8'h34);
    chk(fetch_addr, 13'h0834);
    chk(pc_low_byte, 8'h34);
  endtask : t_page
  // Nine calls, so the last one lands on the oldest entry
  task t_stack;
    wr(3'h1, 8'h18);
    for (int i = 0; i < 9; i++) run(PCS_OP_CALL, 11'h100 + 11'(i));
    for (int i = 0; i < 9; i++) begin
      run(PCS_OP_RETURN);
      chk(fetch_addr, {2'h3, 11'h100 + 11'(i < 8 ? 7 - i : 7)});
    end
    chk(pc_high_latch, 8'h18);
    step(PCS_OP_CALL, 11'h055);
    step(PCS_OP_RETURN);
    step(PCS_OP_INTR);
    run(PCS_OP_HOLD);
    chk(fetch_addr, 13'h0abc);
    run(PCS_OP_RETURN);
    chk(fetch_addr, 13'h1907);
  endtask : t_stack
  task t_ind;
    wr(3'h2, 8'h05);
    chk(indirect_addr, 9'h105);
    chk(indirect_data_port, 8'h50);
    chk(indirect_read_en, 1'h1);
    chk(indirect_write_en, 1'h1);
    wr(3'h2, 8'h00);
    chk(indirect_data_port, 8'h00);
    chk(indirect_read_en, 1'h0);
    chk(indirect_write_en, 1'h0);
  endtask : t_ind
  task summarize;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'h1;
    #1;
    chk(fetch_addr, 13'h0);
    t_page;
    t_stack;
    t_ind;
    summarize;
  end
endmodule : pcs_core_test
bind pcs_core pcs_core_monitor mon (.*);

/* File: bench/pcs_file_model.sv */
// Register file stand-in for indirect reads
`timescale 1ns/100ps
module pcs_file_model (
  input  logic [8:0] indirect_addr,
  output logic [7:0] file_read_data
);
  // Address-derived data, so a wrong address shows
  assign file_read_data = indirect_addr[7:0] ^ {7'h2a, indirect_addr[8]};
endmodule : pcs_file_model

/* File: rtl/pcs_core.sv */
// Program counter, return stack, high latch and indirect address logic
// Summary of operation
// - A 13-bit program counter addresses the next instruction fetch.
// - Program counter low byte is a readable and writable data register.
// - Upper counter bits are never accessed directly; they load from the high latch.
// - Eight-entry, 13-bit return stack outside program and data spaces.
// - Stack pointer has no software read or write path.
// - Call or interrupt branch pushes the program counter.
// - Return, return-with-literal and return-from-interrupt pop into the counter.
// - Push and pop leave the high latch unchanged.
// - Stack is circular; ninth push overwrites first, no overflow flag.
// - Call and jump carry an 11-bit target within a 2K page.
// - Page-select bits of target come from high latch bits 4:3.
// - Full 13-bit counter is pushed, so returns need no page fixing.
// - Indirect port accesses the register addressed by the pointer.
// - Indirect read of the port itself returns 00h.
// - Indirect write to the port itself stores nothing.
// - Effective address is bank bit (status bit 7) joined to pointer.
`timescale 1ns/100ps
module pcs_core
  import pcs_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  input  wire pcs_op_type        flow_op,
  input  wire logic [PAGE_W-1:0] target_addr,
  input  wire logic [PC_W-1:0]   intr_vector,
  input  wire logic              pc_low_write,
  input  wire logic              latch_write,
  input  wire logic              pointer_write,
  input  wire logic [DATA_W-1:0] write_data,
  input  wire logic [DATA_W-1:0] status_reg,
  input  wire logic              port_read,
  input  wire logic              port_write,
  input  wire logic [DATA_W-1:0] file_read_data,
  output logic      [PC_W-1:0]   fetch_addr,
  output logic      [DATA_W-1:0] pc_low_byte,
  output logic      [DATA_W-1:0] pc_high_latch,
  output logic      [DATA_W-1:0] indirect_pointer,
  output logic      [EA_W-1:0]   indirect_addr,
  output logic                   indirect_read_en,
  output logic                   indirect_write_en,
  output logic      [DATA_W-1:0] indirect_data_port
);

  logic [PC_W-1:0]   pc_q, pc_d;
  logic [DATA_W-1:0] latch_q, latch_d;
  logic [DATA_W-1:0] ptr_q, ptr_d;
  logic [SP_W-1:0]   sp_q, sp_d;
  logic [PC_W-1:0]   stack_q [STACK_DEPTH];
  logic              push;
  logic [SP_W-1:0]   top_idx;
  logic              ptr_is_port;

  function automatic logic [SP_W-1:0] sp_step(input logic [SP_W-1:0] sp, input logic up);
    sp_step = up ? SP_W'(sp + 1'b1) : SP_W'(sp - 1'b1);
  endfunction : sp_step

  assign top_idx = sp_step(sp_q, 1'b0);

  // Program counter, latch, pointer and stack pointer next values
  always_comb begin
    pc_d    = pc_q;
    latch_d = latch_q;
    ptr_d   = ptr_q;
    sp_d    = sp_q;
    push    = 1'b0;
    if (latch_write) begin
      latch_d = write_data;
    end
    if (pointer_write) begin
      ptr_d = write_data;
    end
    unique case (flow_op)
      PCS_OP_NEXT: begin
        pc_d = PC_W'(pc_q + 1'b1);
      end
      PCS_OP_JUMP: begin
        pc_d = {latch_q[4], latch_q[PAGE_SEL_BIT], target_addr};
      end
      PCS_OP_CALL: begin
        pc_d = {latch_q[4], latch_q[PAGE_SEL_BIT], target_addr};
        push = 1'b1;
      end
      PCS_OP_INTR: begin
        pc_d = intr_vector;
        push = 1'b1;
      end
      PCS_OP_RETURN: begin
        pc_d = stack_q[top_idx];
        sp_d = top_idx;
      end
      PCS_OP_HOLD: begin
        pc_d = pc_q;
      end
      default: begin
        pc_d = pc_q;
      end
    endcase
    if (push) begin
      sp_d = sp_step(sp_q, 1'b1);
    end
    // Low byte write loads the whole counter; latch not yet updated this cycle
    if (pc_low_write && (flow_op == PCS_OP_NEXT || flow_op == PCS_OP_HOLD)) begin
      pc_d = {latch_q[PC_W-DATA_W-1:0], write_data};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pc_q    <= PC_RESET;
      latch_q <= LATCH_RESET;
      ptr_q   <= POINTER_RESET;
      sp_q    <= SP_RESET;
    end else if (clk_en) begin
      pc_q    <= pc_d;
      latch_q <= latch_d;
      ptr_q   <= ptr_d;
      sp_q    <= sp_d;
    end
  end

  // Stack storage has no reset; stale entries are harmless by design
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      stack_q[sp_q] <= pc_q;
    end
  end

  // Indirect addressing; ports are combinational handshakes into the file
  assign ptr_is_port       = (ptr_q == PORT_ADDR);
  assign indirect_addr     = {status_reg[BANK_SEL_BIT], ptr_q};
  assign indirect_read_en  = port_read && !ptr_is_port;
  assign indirect_write_en = port_write && !ptr_is_port;
  assign indirect_data_port = ptr_is_port ? NULL_READ : file_read_data;

  assign fetch_addr       = pc_q;
  assign pc_low_byte      = pc_q[DATA_W-1:0];
  assign pc_high_latch    = latch_q;
  assign indirect_pointer = ptr_q;

endmodule : pcs_core

/* File: rtl/pcs_pkg.sv */
// Package of constants and types for the program flow and indirect addressing block
package pcs_pkg;
  localparam int PC_W             = 13;
  localparam int PAGE_W           = 11;
  localparam int STACK_DEPTH      = 8;
  localparam int SP_W             = 3;
  localparam int DATA_W           = 8;
  localparam int EA_W             = 9;
  localparam int PAGE_SEL_BIT     = 3;
  localparam int BANK_SEL_BIT     = 7;
  localparam logic [PC_W-1:0]   PC_RESET      = 13'h0000;
  localparam logic [DATA_W-1:0] LATCH_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] POINTER_RESET = 8'h00;
  localparam logic [SP_W-1:0]   SP_RESET      = 3'h0;
  localparam logic [DATA_W-1:0] PORT_ADDR     = 8'h00;
  localparam logic [DATA_W-1:0] NULL_READ     = 8'h00;

  typedef enum logic [5:0] {
    PCS_OP_NEXT   = 6'b000001,
    PCS_OP_JUMP   = 6'b000010,
    PCS_OP_CALL   = 6'b000100,
    PCS_OP_INTR   = 6'b001000,
    PCS_OP_RETURN = 6'b010000,
    PCS_OP_HOLD   = 6'b100000
  } pcs_op_type;
endpackage : pcs_pkg
